// ### logic/msmd_pkg.sv
/*
  constants and types for the motion search message decoder.
  assumes one core clock and a thread that presents one request at a time.
*/
// Summary of operation
// - eight skip enable bits in dword 7 bits 31:24 mark pairs valid.
// - four skip centres per reference, fetched from that reference surface.
// - skip vectors accepted over full horizontal and vertical range.
// - intra mode mask 9+9+4 bits removes modes for whole macroblock.
// - buffer surfaces only; data returned without format conversion.
// - reads outside the surface replicate edge pixels.
// - stream-in adds four phases for code 111, else two.
// - stream-out adds four phases for code 111, else two.
// - descriptor bits 14:13 give message type.
// - bits 12:11 cost table subindex, bits 10:8 search path index.
// - bits 7:0 source binding index; references at plus one, two.
// - inter requests 5 in, 6 out; intra only 5 in, 1 out.
// - window height and width multiples of 4 from 20 to 64.
// - dword 5 bits 7:0 dispatch id frees thread resources.
// - dword 3 bits 30:24 partition disable mask.
// - inter adjust 00 none, 10 haar, others reserved.
// - dword 3 bit 19 selects maximum block distortion skip test.
// - search control 111 selects dual reference dual record.
package msmd_pkg;
  localparam int DSC_HDR_BIT = 19;
  localparam int DSC_SIN_BIT = 16;
  localparam int DSC_SOUT_BIT = 15;
  localparam int DSC_TYPE_LO = 13;
  localparam int DSC_SUBIDX_LO = 11;
  localparam int DSC_PATH_LO = 8;
  localparam int DW5_HEIGHT_LO = 24;
  localparam int DW5_WIDTH_LO = 16;
  localparam int DW3_PART_LO = 24;
  localparam int DW3_INTRA_ADJ_LO = 22;
  localparam int DW3_INTER_ADJ_LO = 20;
  localparam int DW3_BLKSKIP_BIT = 19;
  localparam int DW3_SCTRL_LO = 8;
  localparam int DW7_SKIPEN_LO = 24;
  localparam logic [2:0] SCTRL_DUAL = 3'h7;
  localparam logic [7:0] BTI_MAX = 8'hfe;
  localparam logic [7:0] WIN_MIN = 8'h14;
  localparam logic [7:0] WIN_MAX = 8'h40;
  localparam logic [7:0] WIN_BASE = 8'h10;
  localparam logic [3:0] IN_BASE = 4'h5;
  localparam logic [3:0] OUT_INTER = 4'h6;
  localparam logic [3:0] OUT_INTRA = 4'h1;
  localparam logic [3:0] STREAM_DUAL = 4'h4;
  localparam logic [3:0] STREAM_SINGLE = 4'h2;
  localparam logic [1:0] ADJ_NONE = 2'h0;
  localparam logic [1:0] ADJ_HAAR = 2'h2;
  localparam int REF_HALF = 4;
  localparam logic DESC_RST = 1'b0;
  typedef enum logic [1:0] {
    MSMD_TYPE_RSVD = 2'h0,
    MSMD_TYPE_INTER = 2'h1,
    MSMD_TYPE_INTRA = 2'h2,
    MSMD_TYPE_BOTH = 2'h3
  } msmd_type_t;
  typedef enum logic [2:0] {
    MSMD_ST_IDLE = 3'b001,
    MSMD_ST_DECODE = 3'b010,
    MSMD_ST_ISSUE = 3'b100
  } msmd_state_t;
endpackage

// ### logic/msmd_buf2.sv
/*
  two-entry buffer with valid and ready on both sides.
  assumes source and sink on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module msmd_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [2];
  logic [WIDTH-1:0] mem_nxt [2];
  logic rd_r, rd_nxt, wr_r, wr_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;

  initial begin
    if (WIDTH < 1) $error("msmd_buf2 width");
  end

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
      wr_nxt = ~wr_r;
    end
    if (pop) begin
      rd_nxt = ~rd_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end

  a_buf_count: assert property (@(posedge clk) disable iff (srst) cnt_r <= 2'h2)
    else $error("buffer count over two");
endmodule
`default_nettype wire

// ### logic/msmd_decoder.sv
/*
  motion search message decoder: takes descriptor and header dwords,
  produces one decoded word per request through a two-entry buffer.
  assumes the thread holds the request until REQ_READY.
*/
`timescale 1ns/1ps
`default_nettype none
module msmd_decoder
  import msmd_pkg::*;
#(
  parameter int SKIP_PAIRS = 8
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [31:0] REQ_DESC,
  input wire logic [31:0] REQ_DW3,
  input wire logic [31:0] REQ_DW5,
  input wire logic [31:0] REQ_DW7,
  input wire logic [21:0] REQ_INTRA_MASK,
  input wire logic SKIP_ONE_PAIR,
  input wire logic SURF_IS_BUFFER,
  input wire logic [15:0] SURF_X,
  input wire logic [15:0] SURF_Y,
  input wire logic [15:0] SURF_W,
  input wire logic [15:0] SURF_H,
  output logic [15:0] FETCH_X,
  output logic [15:0] FETCH_Y,
  output logic DEC_VALID,
  input wire logic DEC_READY,
  output logic [1:0] DEC_TYPE,
  output logic [3:0] DEC_IN_PHASES,
  output logic [3:0] DEC_OUT_PHASES,
  output logic [1:0] DEC_COST_SUBIDX,
  output logic [2:0] DEC_PATH_IDX,
  output logic [7:0] DEC_SRC_BTI,
  output logic [7:0] DEC_FWD_BTI,
  output logic [7:0] DEC_BWD_BTI,
  output logic [7:0] DEC_SEARCH_H,
  output logic [7:0] DEC_SEARCH_W,
  output logic [7:0] DEC_DISPATCH_ID,
  output logic [6:0] DEC_PART_MASK,
  output logic [1:0] DEC_INTER_ADJ,
  output logic [1:0] DEC_INTRA_ADJ,
  output logic DEC_BLOCK_SKIP,
  output logic DEC_DUAL_REF,
  output logic [7:0] DEC_SKIP_EN,
  output logic [3:0] DEC_SKIP_EN_REF0,
  output logic [3:0] DEC_SKIP_EN_REF1,
  output logic [21:0] DEC_INTRA_MASK,
  output logic DEC_ERROR,
  output logic [7:0] RELEASE_ID,
  output logic RELEASE_STB
);
  // ****************************************
  // decode helpers
  // ****************************************
  localparam int DW = 2 + 4 + 4 + 2 + 3 + 24 + 8 + 8 + 8 + 7 + 2 + 2 + 1 + 1 + 8 + 22 + 1;

  initial begin
    if (SKIP_PAIRS != 8) $error("msmd_decoder skip pairs must be 8");
  end

  function automatic logic [3:0] stream_phases(input logic [2:0] sctrl);
    stream_phases = (sctrl == SCTRL_DUAL) ? STREAM_DUAL : STREAM_SINGLE;
  endfunction

  function automatic logic win_ok(input logic [7:0] v);
    win_ok = (v >= WIN_MIN) && (v <= WIN_MAX) && (v[1:0] == 2'h0);
  endfunction

  function automatic logic [15:0] clamp(input logic [15:0] p, input logic [15:0] lim);
    if (p[15]) begin
      clamp = 16'h0000;
    end else if (p >= lim) begin
      clamp = (lim == 16'h0000) ? 16'h0000 : lim - 16'h0001;
    end else begin
      clamp = p;
    end
  endfunction

  // ****************************************
  // state machine and captured request
  // ****************************************
  msmd_state_t st_r, st_nxt;
  logic [31:0] desc_r, desc_nxt, dw3_r, dw3_nxt, dw5_r, dw5_nxt, dw7_r, dw7_nxt;
  logic [21:0] imask_r, imask_nxt;
  logic one_r, one_nxt, buf_r, buf_nxt;
  logic [DW-1:0] word_r, word_nxt;
  logic rel_r, rel_nxt;
  logic [7:0] relid_r, relid_nxt;
  logic [15:0] fx_r, fx_nxt, fy_r, fy_nxt;
  logic bin_ready, bin_valid;
  logic [DW-1:0] bout;

  logic [1:0] mtype;
  logic [2:0] sctrl;
  logic [3:0] sph_in, sph_out, in_ph, out_ph;
  logic [7:0] hgt, wid, skipen, bti;
  logic bad;

  assign REQ_READY = (st_r == MSMD_ST_IDLE);
  assign bin_valid = (st_r == MSMD_ST_ISSUE);

  always_comb begin
    mtype = desc_r[DSC_TYPE_LO +: 2];
    sctrl = dw3_r[DW3_SCTRL_LO +: 3];
    sph_in = desc_r[DSC_SIN_BIT] ? stream_phases(sctrl) : 4'h0;
    sph_out = desc_r[DSC_SOUT_BIT] ? stream_phases(sctrl) : 4'h0;
    if (mtype == MSMD_TYPE_INTRA) begin
      in_ph = IN_BASE;
      out_ph = OUT_INTRA;
    end else begin
      in_ph = IN_BASE + sph_in;
      out_ph = OUT_INTER + sph_out;
    end
    hgt = dw5_r[DW5_HEIGHT_LO +: 8];
    wid = dw5_r[DW5_WIDTH_LO +: 8];
    bti = desc_r[7:0];
    skipen = dw7_r[DW7_SKIPEN_LO +: 8]; // no vector range test
    if (one_r) begin
      skipen[7:1] = 7'h00; // only the first pair is used
    end
    bad = (mtype == MSMD_TYPE_RSVD) || (bti > BTI_MAX) || !buf_r
      || !win_ok(hgt) || !win_ok(wid)
      || (dw3_r[DW3_INTER_ADJ_LO +: 2] != ADJ_NONE
          && dw3_r[DW3_INTER_ADJ_LO +: 2] != ADJ_HAAR);
  end

  always_comb begin
    st_nxt = st_r;
    desc_nxt = desc_r;
    dw3_nxt = dw3_r;
    dw5_nxt = dw5_r;
    dw7_nxt = dw7_r;
    imask_nxt = imask_r;
    one_nxt = one_r;
    buf_nxt = buf_r;
    word_nxt = word_r;
    rel_nxt = 1'b0;
    relid_nxt = relid_r;
    case (st_r)
      MSMD_ST_IDLE: begin
        if (REQ_VALID) begin
          desc_nxt = REQ_DESC;
          dw3_nxt = REQ_DW3;
          dw5_nxt = REQ_DW5;
          dw7_nxt = REQ_DW7;
          imask_nxt = REQ_INTRA_MASK;
          one_nxt = SKIP_ONE_PAIR;
          buf_nxt = SURF_IS_BUFFER;
          st_nxt = MSMD_ST_DECODE;
        end
      end
      MSMD_ST_DECODE: begin
        word_nxt = {mtype, in_ph, out_ph,
          desc_r[DSC_SUBIDX_LO +: 2], desc_r[DSC_PATH_LO +: 3],
          bti, bti + 8'h01, bti + 8'h02,
          hgt - WIN_BASE, wid - WIN_BASE,
          dw5_r[7:0],
          dw3_r[DW3_PART_LO +: 7],
          dw3_r[DW3_INTER_ADJ_LO +: 2], dw3_r[DW3_INTRA_ADJ_LO +: 2],
          dw3_r[DW3_BLKSKIP_BIT],
          sctrl == SCTRL_DUAL,
          skipen, imask_r, bad};
        st_nxt = MSMD_ST_ISSUE;
      end
      MSMD_ST_ISSUE: begin
        if (bin_ready) begin
          rel_nxt = 1'b1;
          relid_nxt = dw5_r[7:0];
          st_nxt = MSMD_ST_IDLE;
        end
      end
      default: st_nxt = MSMD_ST_IDLE;
    endcase
  end

  // ****************************************
  // out of bounds fetch clamp
  // ****************************************
  always_comb begin
    fx_nxt = clamp(SURF_X, SURF_W);
    fy_nxt = clamp(SURF_Y, SURF_H);
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      st_r <= MSMD_ST_IDLE;
      desc_r <= '0;
      dw3_r <= '0;
      dw5_r <= '0;
      dw7_r <= '0;
      imask_r <= '0;
      one_r <= DESC_RST;
      buf_r <= DESC_RST;
      word_r <= '0;
      rel_r <= 1'b0;
      relid_r <= 8'h00;
      fx_r <= 16'h0000;
      fy_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      desc_r <= desc_nxt;
      dw3_r <= dw3_nxt;
      dw5_r <= dw5_nxt;
      dw7_r <= dw7_nxt;
      imask_r <= imask_nxt;
      one_r <= one_nxt;
      buf_r <= buf_nxt;
      word_r <= word_nxt;
      rel_r <= rel_nxt;
      relid_r <= relid_nxt;
      fx_r <= fx_nxt;
      fy_r <= fy_nxt;
    end
  end

  // ****************************************
  // output buffer
  // ****************************************
  msmd_buf2 #(.WIDTH(DW)) u_buf (
    .clk(REF_CLK),
    .srst(SRST),
    .in_valid(bin_valid),
    .in_ready(bin_ready),
    .in_data(word_r),
    .out_valid(DEC_VALID),
    .out_ready(DEC_READY),
    .out_data(bout)
  );

  assign {DEC_TYPE, DEC_IN_PHASES, DEC_OUT_PHASES, DEC_COST_SUBIDX, DEC_PATH_IDX,
    DEC_SRC_BTI, DEC_FWD_BTI, DEC_BWD_BTI, DEC_SEARCH_H, DEC_SEARCH_W,
    DEC_DISPATCH_ID, DEC_PART_MASK, DEC_INTER_ADJ, DEC_INTRA_ADJ, DEC_BLOCK_SKIP,
    DEC_DUAL_REF, DEC_SKIP_EN, DEC_INTRA_MASK, DEC_ERROR} = bout;
  assign DEC_SKIP_EN_REF0 = DEC_SKIP_EN[REF_HALF-1:0];
  assign DEC_SKIP_EN_REF1 = DEC_SKIP_EN[2*REF_HALF-1:REF_HALF];
  assign RELEASE_STB = rel_r;
  assign RELEASE_ID = relid_r;
  assign FETCH_X = fx_r;
  assign FETCH_Y = fy_r;

  // ****************************************
  // assertions
  // ****************************************
  a_in_phases: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE && mtype != MSMD_TYPE_INTRA && desc_r[DSC_SIN_BIT]
    |-> ##1 word_r[DW-3 -: 4] == (sctrl == SCTRL_DUAL ? 4'h9 : 4'h7))
    else $error("stream-in phase count wrong");
  a_out_phases: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE && mtype != MSMD_TYPE_INTRA && desc_r[DSC_SOUT_BIT]
    |-> ##1 word_r[DW-7 -: 4] == (sctrl == SCTRL_DUAL ? 4'ha : 4'h8))
    else $error("stream-out phase count wrong");
  a_intra_len: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE && mtype == MSMD_TYPE_INTRA
    |-> ##1 word_r[DW-3 -: 8] == 8'h51)
    else $error("intra lengths wrong");
  a_type_pass: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE |-> ##1 word_r[DW-1 -: 2] == $past(desc_r[14:13]))
    else $error("message type wrong");
  a_ref_bti: assert property (@(posedge REF_CLK) disable iff (SRST)
    DEC_VALID |-> DEC_FWD_BTI == DEC_SRC_BTI + 8'h01 && DEC_BWD_BTI == DEC_SRC_BTI + 8'h02)
    else $error("reference binding index wrong");
  a_release_once: assert property (@(posedge REF_CLK) disable iff (SRST)
    RELEASE_STB |-> ##1 !RELEASE_STB)
    else $error("release pulse too long");
  a_one_pair: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE && one_r |-> ##1 word_r[30:24] == 7'h00)
    else $error("one pair mode leaked enables");
  a_fetch_in: assert property (@(posedge REF_CLK) disable iff (SRST)
    SURF_W != 16'h0000 && !SURF_X[15] |=> FETCH_X < $past(SURF_W))
    else $error("fetch outside surface");
  a_search_h: assert property (@(posedge REF_CLK) disable iff (SRST)
    DEC_VALID && !DEC_ERROR |-> DEC_SEARCH_H <= 8'h30)
    else $error("search points out of range");
  a_type_err: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE && mtype == MSMD_TYPE_RSVD |-> ##1 word_r[0])
    else $error("reserved type not flagged");
  a_bti_err: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE && bti > BTI_MAX |-> ##1 word_r[0])
    else $error("binding index not flagged");
  a_surf_err: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE && !buf_r |-> ##1 word_r[0])
    else $error("surface type not flagged");
  a_win_err: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE && !(win_ok(hgt) && win_ok(wid)) |-> ##1 word_r[0])
    else $error("window size not flagged");
  a_adj_err: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE && dw3_r[DW3_INTER_ADJ_LO] |-> ##1 word_r[0])
    else $error("reserved adjust not flagged");
  a_dual_sel: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE |-> ##1 word_r[31] == (sctrl == SCTRL_DUAL))
    else $error("dual reference select wrong");
  a_part_pass: assert property (@(posedge REF_CLK) disable iff (SRST)
    st_r == MSMD_ST_DECODE |-> ##1 word_r[43:37] == dw3_r[DW3_PART_LO +: 7])
    else $error("partition mask wrong");
  c_dual: cover property (@(posedge REF_CLK) DEC_VALID && DEC_DUAL_REF);
  c_err: cover property (@(posedge REF_CLK) DEC_VALID && DEC_ERROR);
  c_intra: cover property (@(posedge REF_CLK) DEC_VALID && DEC_TYPE == MSMD_TYPE_INTRA);
  c_stall: cover property (@(posedge REF_CLK) DEC_VALID && !DEC_READY ##1 !REQ_READY);
endmodule
`default_nettype wire

// ### test/msmd_thread_model.sv
/*
  requesting thread model: presents one request, holds it until taken.
  assumes a single core clock; the bench calls send() by hierarchy.
*/
`timescale 1ns/1ps
`default_nettype none
module msmd_thread_model (
  input wire logic clk,
  input wire logic req_ready,
  output logic req_valid,
  output logic [31:0] req_desc,
  output logic [31:0] req_dw3,
  output logic [31:0] req_dw5,
  output logic [31:0] req_dw7
);
  initial begin
    req_valid = 1'b0;
    req_desc = 32'h0;
    req_dw3 = 32'h0;
    req_dw5 = 32'h0;
    req_dw7 = 32'h0;
  end
  // one request at a time, never with sampler traffic pending
  // no end of thread flag is ever raised on these messages
  task automatic send(input logic [31:0] d, input logic [31:0] w3, w5, w7);
    @(negedge clk);
    req_valid = 1'b1;
    req_desc = d | 32'h0008_0000; // header present always set
    req_dw3 = w3;
    req_dw5 = w5;
    req_dw7 = w7;
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    // released lines scrambled
    req_valid = 1'b0;
    req_desc = ~req_desc;
    req_dw3 = ~req_dw3;
    req_dw5 = ~req_dw5;
    req_dw7 = ~req_dw7;
  endtask
endmodule
`default_nettype wire

// ### test/motion_search_message_decoder_tb.sv
/*
  self-checking bench for the message decoder, one task per scenario.
  assumes the package, design files and thread model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module motion_search_message_decoder_tb;
  import msmd_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic dec_ready = 1'b0;
  logic one_pair = 1'b0;
  logic is_buf = 1'b1;
  logic [21:0] imask = 22'h0;
  logic [15:0] sx = 16'h0, sy = 16'h0, sw = 16'h0064, sh = 16'h0032;
  int fail_count = 0;
  int num_checks = 0;
  wire logic req_valid, req_ready, dec_valid, blk_skip, dual_ref, dec_err, rel_stb;
  wire logic [1:0] dtype, csub, iadj, eadj;
  wire logic [2:0] path;
  wire logic [3:0] inph, outph, sen0, sen1;
  wire logic [6:0] pmask;
  wire logic [7:0] src, fwd, bwd, srh, srw, did, sen, rel_id;
  wire logic [15:0] fx, fy;
  wire logic [21:0] dmask;
  wire logic [31:0] desc, dw3, dw5, dw7;
  always #4 ref_clk = ~ref_clk;
  msmd_thread_model u_thr (.clk(ref_clk), .req_ready(req_ready), .req_valid(req_valid),
    .req_desc(desc), .req_dw3(dw3), .req_dw5(dw5), .req_dw7(dw7));
  msmd_decoder u_dut (.REF_CLK(ref_clk), .SRST(srst), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_DESC(desc), .REQ_DW3(dw3), .REQ_DW5(dw5), .REQ_DW7(dw7),
    .REQ_INTRA_MASK(imask), .SKIP_ONE_PAIR(one_pair), .SURF_IS_BUFFER(is_buf),
    .SURF_X(sx), .SURF_Y(sy), .SURF_W(sw), .SURF_H(sh), .FETCH_X(fx), .FETCH_Y(fy),
    .DEC_VALID(dec_valid), .DEC_READY(dec_ready), .DEC_TYPE(dtype), .DEC_IN_PHASES(inph),
    .DEC_OUT_PHASES(outph), .DEC_COST_SUBIDX(csub), .DEC_PATH_IDX(path), .DEC_SRC_BTI(src),
    .DEC_FWD_BTI(fwd), .DEC_BWD_BTI(bwd), .DEC_SEARCH_H(srh), .DEC_SEARCH_W(srw),
    .DEC_DISPATCH_ID(did), .DEC_PART_MASK(pmask), .DEC_INTER_ADJ(eadj), .DEC_INTRA_ADJ(iadj),
    .DEC_BLOCK_SKIP(blk_skip), .DEC_DUAL_REF(dual_ref), .DEC_SKIP_EN(sen),
    .DEC_SKIP_EN_REF0(sen0), .DEC_SKIP_EN_REF1(sen1), .DEC_INTRA_MASK(dmask),
    .DEC_ERROR(dec_err), .RELEASE_ID(rel_id), .RELEASE_STB(rel_stb));
  // ****************************************
  // shared helpers
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_valid;
    int n;
    n = 0;
    while (dec_valid !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk("dec_valid", dec_valid, 1'b1);
  endtask
  function automatic logic bad_win(input logic [7:0] v);
    return (v < 8'h14) || (v > 8'h40) || (v[1:0] != 2'h0);
  endfunction
  task automatic req_check(input logic [31:0] d, w3, w5, w7);
    logic [1:0] t;
    logic [3:0] st;
    logic err;
    logic [7:0] en;
    t = d[14:13];
    st = (w3[10:8] == 3'h7) ? 4'h4 : 4'h2;
    err = (t == 2'h0) || (d[7:0] == 8'hff) || !is_buf || bad_win(w5[31:24]);
    err = err || bad_win(w5[23:16]) || w3[20];
    en = one_pair ? {7'h0, w7[24]} : w7[31:24];
    u_thr.send(d, w3, w5, w7);
    wait_valid();
    chk("release_stb", rel_stb, 1'b1);
    chk("release_id", rel_id, w5[7:0]);
    chk("error", dec_err, err);
    if (t != 2'h0) begin
      chk("type", dtype, t);
      chk("in_phases", inph, (t == 2'h2) ? 4'h5 : 4'h5 + (d[16] ? st : 4'h0));
      chk("out_phases", outph, (t == 2'h2) ? 4'h1 : 4'h6 + (d[15] ? st : 4'h0));
    end
    chk("cost_subidx", csub, d[12:11]);
    chk("path_idx", path, d[10:8]);
    chk("src_bti", src, d[7:0]);
    chk("fwd_bti", fwd, 8'(d[7:0] + 8'h1));
    chk("bwd_bti", bwd, 8'(d[7:0] + 8'h2));
    if (!err) chk("search_h", srh, w5[31:24] - 8'h10);
    if (!err) chk("search_w", srw, w5[23:16] - 8'h10);
    chk("dispatch_id", did, w5[7:0]);
    chk("part_mask", pmask, w3[30:24]);
    chk("inter_adj", eadj, w3[21:20]);
    chk("intra_adj", iadj, w3[23:22]);
    chk("block_skip", blk_skip, w3[19]);
    chk("dual_ref", dual_ref, w3[10:8] == 3'h7);
    chk("skip_en", sen, en);
    chk("skip_ref0", sen0, en[3:0]);
    chk("skip_ref1", sen1, en[7:4]);
    chk("intra_mask", dmask, imask);
    dec_ready = 1'b1;
    @(negedge ref_clk);
    dec_ready = 1'b0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk("ready_rst", req_ready, 1'b1);
    chk("valid_rst", dec_valid, 1'b0);
    chk("stb_rst", rel_stb, 1'b0);
  endtask
  task automatic t_types;
    logic [31:0] d;
    for (int ty = 0; ty < 4; ty++) begin
      for (int k = 0; k < 4; k++) begin
        d = {15'h0, k[0], k[1], ty[1:0], 13'h0010};
        req_check(d, {21'h0, (ty[0] ^ k[0]) ? 3'h7 : 3'h0, 8'h0}, 32'h4020_0005, 32'h0f00_0000);
      end
    end
  endtask
  task automatic t_fields;
    imask = 22'h2a_5a5a;
    // frame source, so intra adjust 10 is allowed
    req_check(32'h0000_7dfd, 32'h5589_0700, 32'h1414_00a7, 32'ha500_0000);
    one_pair = 1'b1;
    req_check(32'h0000_2b00, 32'h2a20_0300, 32'h4040_0033, 32'h0100_0000);
    one_pair = 1'b0;
  endtask
  task automatic t_errors;
    req_check(32'h0000_20ff, 32'h0, 32'h4040_0001, 32'h0100_0000);
    req_check(32'h0000_2001, 32'h0, 32'h1640_0002, 32'h0100_0000);
    req_check(32'h0000_2001, 32'h0, 32'h4044_0003, 32'h0100_0000);
    req_check(32'h0000_2001, 32'h0010_0000, 32'h4040_0004, 32'h0100_0000);
    req_check(32'h0000_2001, 32'h0030_0000, 32'h4040_0005, 32'h0100_0000);
    is_buf = 1'b0;
    req_check(32'h0000_2001, 32'h0, 32'h4040_0006, 32'h0100_0000);
    is_buf = 1'b1;
  endtask
  task automatic t_stall;
    for (int i = 1; i <= 3; i++) begin
      u_thr.send(32'h0000_2010, 32'h0, {24'h4040_00, i[7:0]}, 32'hff00_0000);
    end
    repeat (6) @(negedge ref_clk);
    chk("ready_full", req_ready, 1'b0);
    chk("valid_full", dec_valid, 1'b1);
    for (int i = 1; i <= 3; i++) begin
      wait_valid();
      chk("drain_id", did, i[7:0]);
      dec_ready = 1'b1;
      @(negedge ref_clk);
      dec_ready = 1'b0;
    end
  endtask
  task automatic t_clamp;
    logic [15:0] xs [4] = '{16'hfffb, 16'h0096, 16'h0028, 16'h0063};
    logic [15:0] xe [4] = '{16'h0000, 16'h0063, 16'h0028, 16'h0063};
    for (int i = 0; i < 4; i++) begin
      sx = xs[i];
      sy = xs[i];
      repeat (2) @(negedge ref_clk);
      chk("fetch_x", fx, xe[i]);
      chk("fetch_y", fy, (i == 2) ? 16'h0028 : (i == 0) ? 16'h0000 : 16'h0031);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    t_reset();
    t_types();
    t_fields();
    t_errors();
    t_stall();
    t_clamp();
    tally_and_finish();
  end
endmodule
`default_nettype wire
